// File: verilog/dcf_pkg.sv
`default_nettype none

package dcf_pkg;

	// ************************************************************
	// storage geometry
	// ************************************************************
	localparam int ADDR_W = 13;
	localparam int PTR_W = 14;
	localparam int WORD_W = 18;
	localparam int BYTE_W = 9;
	localparam int OFFSET_W = 13;
	localparam logic [PTR_W-1:0] DEPTH = 14'h2000;
	localparam logic [PTR_W-1:0] HALF_DEPTH = 14'h1000;
	localparam logic [PTR_W-1:0] PTR_RESET = 14'h0000;
	localparam logic [PTR_W-1:0] PTR_STEP = 14'h0001;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [WORD_W-1:0] DATA_RESET = 18'h00000;
	localparam logic [BYTE_W-1:0] BYTE_RESET = 9'h000;

	// ************************************************************
	// default almost-empty / almost-full offsets, one per strap code
	// ************************************************************
	localparam logic [OFFSET_W-1:0] DEF_OFFSET [8] = '{
		13'h0007, 13'h000f, 13'h001f, 13'h003f,
		13'h007f, 13'h00ff, 13'h01ff, 13'h03ff
	};

	// ************************************************************
	// settings caught during master reset
	// ************************************************************
	typedef struct packed {
		logic fall_through_mode;
		logic zero_latency_retx;
		logic lsb_first;
		logic in_x9;
		logic out_x9;
		logic flag_sync;
		logic serial_prog;
	} dcf_cfg_t;

	typedef struct packed {
		logic [OFFSET_W-1:0] empty_off;
		logic [OFFSET_W-1:0] full_off;
	} dcf_offsets_t;

endpackage : dcf_pkg

`default_nettype wire

// File: verilog/dcf_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-stage pointer copy advanced only on the receiving port's edges
module dcf_edge_sync #(
	parameter int W = 14
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] stage1;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stage1 <= '0;
			q <= '0;
		end else if (en) begin
			stage1 <= d;
			q <= stage1;
		end
	end

endmodule : dcf_edge_sync

`default_nettype wire

// File: verilog/dcf_fifo_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - retransmit latency select caught at master reset; low is zero latency
// - zero latency retransmit loads first word on the requesting read edge
// - timing select caught at reset; high fall-through, low standard flags
// - fall-through shows first word after three read edges, no read enable
// - after reset timing select pin is serial offset input if serial chosen
// - write edges release no read-side flag except async almost-empty; half-full only asserted
// - write edge with enable low and not full stores next word
// - full/input-ready released two write edges after freeing read
// - read edges release only half-full and async almost-full; read flags change on read edges
// - read edge with enable low and data present loads output register
// - fall-through read of last word raises output-ready, reads then ignored
// - empty asserted after last read, released two read edges after write
// - serial enable and load low shift one offset bit per write edge
// - output enable only passes to DATA_OUT_EN_N; DATA_OUT is always driven
// - load and two selects at reset pick default offsets and method
// - load low gives offset access; writes by chosen method, reads parallel
// - widths caught at reset; counting in units of the wider bus
// - byte order caught at reset; low gives upper byte first
// - async flags: assert on own side edges, release on other side edges
// - sync flags: almost-empty on read edges, almost-full on write edges
// - retransmit rewinds read pointer only, keeping write pointer and settings
module dcf_fifo_ctrl (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PARTIAL_RST_N,
	input wire logic WR_CLK_EN,
	input wire logic RD_CLK_EN,
	input wire logic WRITE_EN_N,
	input wire logic READ_EN_N,
	input wire logic [17:0] DATA_IN,
	input wire logic TIMING_SEL_SERIAL_IN,
	input wire logic RETRANSMIT_LATENCY_SEL,
	input wire logic RETRANSMIT_REQ_N,
	input wire logic SERIAL_PROG_EN_N,
	input wire logic OFFSET_LOAD_N,
	input wire logic DEFAULT_OFFSET_SEL0,
	input wire logic DEFAULT_OFFSET_SEL1,
	input wire logic IN_WIDTH_SEL,
	input wire logic OUT_WIDTH_SEL,
	input wire logic BYTE_ORDER_SEL_N,
	input wire logic FLAG_TIMING_SEL,
	input wire logic OUTPUT_EN_N,
	output logic [17:0] DATA_OUT,
	output logic DATA_OUT_EN_N,
	output logic FULL_FLAG_N,
	output logic EMPTY_FLAG_N,
	output logic ALMOST_EMPTY_N,
	output logic ALMOST_FULL_N,
	output logic HALF_FULL_N
);

	// ************************************************************
	// lane pick for byte-wide reads of stored words
	// ************************************************************
	function automatic logic [dcf_pkg::WORD_W-1:0] pick_lane(
		input logic [dcf_pkg::WORD_W-1:0] word,
		input logic second,
		input logic lsb_first,
		input logic split
	);
		logic upper;
		upper = (second == lsb_first);
		if (!split)
			return word;
		else if (upper)
			return {dcf_pkg::BYTE_RESET, word[17:9]};
		else
			return {dcf_pkg::BYTE_RESET, word[8:0]};
	endfunction : pick_lane

	dcf_pkg::dcf_cfg_t cfg;
	dcf_pkg::dcf_offsets_t offs;
	logic rst_all_n;
	logic pack_mode;
	logic split_mode;
	logic [dcf_pkg::WORD_W-1:0] mem [dcf_pkg::DEPTH];

	assign rst_all_n = RST_N && PARTIAL_RST_N;
	assign pack_mode = cfg.in_x9 && !cfg.out_x9;
	assign split_mode = !cfg.in_x9 && cfg.out_x9;

	// ************************************************************
	// straps, caught only while master reset is held
	// ************************************************************
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			cfg.zero_latency_retx <= !RETRANSMIT_LATENCY_SEL;
			cfg.fall_through_mode <= TIMING_SEL_SERIAL_IN;
			cfg.lsb_first <= BYTE_ORDER_SEL_N;
			cfg.in_x9 <= IN_WIDTH_SEL;
			cfg.out_x9 <= OUT_WIDTH_SEL;
			cfg.flag_sync <= FLAG_TIMING_SEL;
			cfg.serial_prog <= OFFSET_LOAD_N;
		end
		// nothing else assigns cfg, so it survives partial reset
	end

	// ************************************************************
	// write side
	// ************************************************************
	logic [dcf_pkg::PTR_W-1:0] wr_ptr;
	logic [dcf_pkg::PTR_W-1:0] rd_ptr;
	logic [dcf_pkg::PTR_W-1:0] rd_ptr_wsync;
	logic [dcf_pkg::PTR_W-1:0] wr_ptr_rsync;
	logic [dcf_pkg::PTR_W-1:0] wr_count;
	logic [dcf_pkg::PTR_W-1:0] rd_count;
	logic wr_half;
	logic [dcf_pkg::BYTE_W-1:0] wr_byte;
	logic full;
	logic fifo_write;
	logic commit;
	logic [dcf_pkg::WORD_W-1:0] next_word;

	// read pointer seen by write side only through two write edges
	dcf_edge_sync #(.W(dcf_pkg::PTR_W)) u_rd_to_wr (
		.clk(CLK),
		.rst_n(rst_all_n),
		.en(WR_CLK_EN),
		.d(rd_ptr),
		.q(rd_ptr_wsync)
	);

	assign wr_count = wr_ptr - rd_ptr_wsync;
	assign full = (wr_count >= dcf_pkg::DEPTH);
	assign fifo_write = WR_CLK_EN && OFFSET_LOAD_N && !WRITE_EN_N && !full;
	assign commit = fifo_write && !(pack_mode && !wr_half);

	always_comb begin
		if (pack_mode && cfg.lsb_first)
			next_word = {DATA_IN[8:0], wr_byte};
		else if (pack_mode)
			next_word = {wr_byte, DATA_IN[8:0]};
		else if (cfg.in_x9)
			next_word = {dcf_pkg::BYTE_RESET, DATA_IN[8:0]};
		else
			next_word = DATA_IN;
	end

	always_ff @(posedge CLK) begin
		if (!rst_all_n) begin
			wr_ptr <= dcf_pkg::PTR_RESET;
			wr_half <= 1'b0;
			wr_byte <= dcf_pkg::BYTE_RESET;
		end else if (fifo_write) begin
			if (pack_mode && !wr_half) begin
				wr_byte <= DATA_IN[8:0];
				wr_half <= 1'b1;
			end else begin
				wr_ptr <= wr_ptr + dcf_pkg::PTR_STEP;
				wr_half <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (commit)
			mem[wr_ptr[dcf_pkg::ADDR_W-1:0]] <= next_word;
	end

	// ************************************************************
	// offset registers
	// ************************************************************
	logic off_wsel;
	logic off_rsel;
	logic offset_rd;

	assign offset_rd = RD_CLK_EN && !OFFSET_LOAD_N && !READ_EN_N;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			offs.empty_off <= dcf_pkg::DEF_OFFSET[{OFFSET_LOAD_N, DEFAULT_OFFSET_SEL1,
				DEFAULT_OFFSET_SEL0}];
			offs.full_off <= dcf_pkg::DEF_OFFSET[{OFFSET_LOAD_N, DEFAULT_OFFSET_SEL1,
				DEFAULT_OFFSET_SEL0}];
			off_wsel <= 1'b0;
		end else if (!PARTIAL_RST_N) begin
			off_wsel <= 1'b0;
		end else if (WR_CLK_EN && !OFFSET_LOAD_N) begin
			if (cfg.serial_prog) begin
				if (!SERIAL_PROG_EN_N)
					offs <= {offs.empty_off[11:0], offs.full_off,
						TIMING_SEL_SERIAL_IN};
			end else if (!WRITE_EN_N) begin
				off_wsel <= !off_wsel;
				if (off_wsel)
					offs.full_off <= DATA_IN[12:0];
				else
					offs.empty_off <= DATA_IN[12:0];
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!rst_all_n)
			off_rsel <= 1'b0;
		else if (offset_rd)
			off_rsel <= !off_rsel;
	end

	// ************************************************************
	// read side
	// ************************************************************
	logic rd_half;
	logic out_valid;
	logic retx_blank;
	logic mem_empty;
	logic ren_ok;
	logic retransmit;
	logic retx_load;
	logic pop;
	logic drain;
	logic [dcf_pkg::WORD_W-1:0] data_out;

	// write pointer seen by read side only through two read edges
	dcf_edge_sync #(.W(dcf_pkg::PTR_W)) u_wr_to_rd (
		.clk(CLK),
		.rst_n(rst_all_n),
		.en(RD_CLK_EN),
		.d(wr_ptr),
		.q(wr_ptr_rsync)
	);

	assign rd_count = wr_ptr_rsync - rd_ptr;
	assign mem_empty = (rd_count == dcf_pkg::PTR_RESET);
	assign ren_ok = !READ_EN_N && OFFSET_LOAD_N;
	// requester keeps enables high here; a read enable in the same edge is ignored
	assign retransmit = RD_CLK_EN && !RETRANSMIT_REQ_N;
	assign retx_load = retransmit && cfg.zero_latency_retx &&
		(wr_ptr_rsync != dcf_pkg::PTR_RESET);
	// fall-through fetches on its own into an empty output register
	assign pop = RD_CLK_EN && !retransmit && !mem_empty &&
		(ren_ok || (cfg.fall_through_mode && !out_valid));
	assign drain = RD_CLK_EN && !retransmit && cfg.fall_through_mode && mem_empty &&
		out_valid && ren_ok;

	always_ff @(posedge CLK) begin
		if (!rst_all_n) begin
			rd_ptr <= dcf_pkg::PTR_RESET;
			rd_half <= 1'b0;
		end else if (retransmit) begin
			rd_ptr <= (retx_load && !split_mode) ? dcf_pkg::PTR_STEP : dcf_pkg::PTR_RESET;
			rd_half <= retx_load && split_mode;
		end else if (pop) begin
			if (split_mode && !rd_half) begin
				rd_half <= 1'b1;
			end else begin
				rd_ptr <= rd_ptr + dcf_pkg::PTR_STEP;
				rd_half <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!rst_all_n)
			data_out <= dcf_pkg::DATA_RESET;
		else if (retx_load)
			data_out <= pick_lane(mem[0], 1'b0, cfg.lsb_first, split_mode);
		else if (pop)
			data_out <= pick_lane(mem[rd_ptr[dcf_pkg::ADDR_W-1:0]], rd_half,
				cfg.lsb_first, split_mode);
		else if (offset_rd)
			data_out <= {5'h00, off_rsel ? offs.full_off : offs.empty_off};
		// otherwise the previous word stays put
	end

	always_ff @(posedge CLK) begin
		if (!rst_all_n) begin
			out_valid <= 1'b0;
			retx_blank <= 1'b0;
		end else if (RD_CLK_EN) begin
			retx_blank <= retransmit && !cfg.zero_latency_retx;
			if (retransmit)
				out_valid <= retx_load;
			else if (pop)
				out_valid <= 1'b1;
			else if (drain)
				out_valid <= 1'b0;
		end
	end

	// ************************************************************
	// status flags
	// ************************************************************
	logic [dcf_pkg::PTR_W-1:0] empty_lim;
	logic [dcf_pkg::PTR_W-1:0] full_lim;
	logic rd_low;
	logic wr_low;
	logic wr_high;
	logic rd_high;
	logic almost_empty_n;
	logic almost_full_n;
	logic half_full_n;

	// fall-through counts the word parked in the output register as well
	assign empty_lim = {1'b0, offs.empty_off} + {13'h0000, cfg.fall_through_mode};
	assign full_lim = dcf_pkg::DEPTH - {1'b0, offs.full_off};
	assign rd_low = (rd_count <= empty_lim);
	assign wr_low = (wr_count <= empty_lim);
	assign wr_high = (wr_count >= full_lim);
	assign rd_high = (rd_count >= full_lim);

	always_ff @(posedge CLK) begin
		if (!rst_all_n) begin
			almost_empty_n <= 1'b0;
		end else if (cfg.flag_sync) begin
			if (RD_CLK_EN)
				almost_empty_n <= !rd_low;
		end else if (RD_CLK_EN && rd_low) begin
			almost_empty_n <= 1'b0;
		end else if (WR_CLK_EN && !wr_low) begin
			almost_empty_n <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!rst_all_n) begin
			almost_full_n <= 1'b1;
		end else if (cfg.flag_sync) begin
			if (WR_CLK_EN)
				almost_full_n <= !wr_high;
		end else if (WR_CLK_EN && wr_high) begin
			almost_full_n <= 1'b0;
		end else if (RD_CLK_EN && !rd_high) begin
			almost_full_n <= 1'b1;
		end
	end

	// write edges may only set it, read edges may only clear it
	always_ff @(posedge CLK) begin
		if (!rst_all_n)
			half_full_n <= 1'b1;
		else if (WR_CLK_EN && wr_count > dcf_pkg::HALF_DEPTH)
			half_full_n <= 1'b0;
		else if (RD_CLK_EN && rd_count <= dcf_pkg::HALF_DEPTH)
			half_full_n <= 1'b1;
	end

	// ************************************************************
	// pins
	// ************************************************************
	// inputs of the full, empty and data terms change only on their own port's edges
	assign FULL_FLAG_N = cfg.fall_through_mode ? full : !full;
	assign EMPTY_FLAG_N = cfg.fall_through_mode ? !out_valid : !(mem_empty || retx_blank);
	assign ALMOST_EMPTY_N = almost_empty_n;
	assign ALMOST_FULL_N = almost_full_n;
	assign HALF_FULL_N = half_full_n;
	assign DATA_OUT = data_out;
	assign DATA_OUT_EN_N = OUTPUT_EN_N;

endmodule : dcf_fifo_ctrl

`default_nettype wire

// File: tb/dcf_fifo_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none

module dcf_fifo_ctrl_sva (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PARTIAL_RST_N,
	input wire logic WR_CLK_EN,
	input wire logic RD_CLK_EN,
	input wire logic OUTPUT_EN_N,
	input wire logic OUT_WIDTH_SEL,
	input wire logic [17:0] DATA_OUT,
	input wire logic DATA_OUT_EN_N,
	input wire logic FULL_FLAG_N,
	input wire logic EMPTY_FLAG_N,
	input wire logic ALMOST_EMPTY_N,
	input wire logic ALMOST_FULL_N,
	input wire logic HALF_FULL_N
);
	logic out_x9;

	// strap copy, so later pin activity cannot move it
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			out_x9 <= OUT_WIDTH_SEL;
		end
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence s_quiet_wr;
		PARTIAL_RST_N && !WR_CLK_EN;
	endsequence
	sequence s_quiet_rd;
		PARTIAL_RST_N && !RD_CLK_EN;
	endsequence

	property p_oe;
		DATA_OUT_EN_N == OUTPUT_EN_N;
	endproperty
	property p_dout_hold;
		s_quiet_rd |=> $stable(DATA_OUT);
	endproperty
	property p_full_hold;
		s_quiet_wr |=> $stable(FULL_FLAG_N);
	endproperty
	property p_empty_hold;
		s_quiet_rd |=> $stable(EMPTY_FLAG_N);
	endproperty
	property p_half_fall;
		$fell(HALF_FULL_N) |-> $past(WR_CLK_EN);
	endproperty
	property p_half_rise;
		$rose(HALF_FULL_N) |-> $past(RD_CLK_EN) || !$past(PARTIAL_RST_N) || !$past(RST_N);
	endproperty
	property p_ae_fall;
		$fell(ALMOST_EMPTY_N) |-> $past(RD_CLK_EN) || !$past(PARTIAL_RST_N) || !$past(RST_N);
	endproperty
	property p_af_fall;
		$fell(ALMOST_FULL_N) |-> $past(WR_CLK_EN);
	endproperty
	property p_x9_upper;
		out_x9 |-> DATA_OUT[17:9] == 9'h000;
	endproperty

	a_oe: assert property (p_oe) else $error("data enable differs from output enable");
	a_dout_hold: assert property (p_dout_hold) else $error("data moved without read edge");
	a_full_hold: assert property (p_full_hold) else $error("full moved without write edge");
	a_empty_hold: assert property (p_empty_hold) else $error("empty moved without read edge");
	a_half_fall: assert property (p_half_fall) else $error("half full set off a write edge");
	a_half_rise: assert property (p_half_rise) else $error("half full cleared off a read edge");
	a_ae_fall: assert property (p_ae_fall) else $error("almost empty set off a read edge");
	a_af_fall: assert property (p_af_fall) else $error("almost full set off a write edge");
	a_x9_upper: assert property (p_x9_upper) else $error("upper byte not zero in byte mode");
endmodule : dcf_fifo_ctrl_sva

bind dcf_fifo_ctrl dcf_fifo_ctrl_sva u_sva (.CLK(CLK), .RST_N(RST_N),
	.PARTIAL_RST_N(PARTIAL_RST_N), .WR_CLK_EN(WR_CLK_EN), .RD_CLK_EN(RD_CLK_EN),
	.OUTPUT_EN_N(OUTPUT_EN_N), .OUT_WIDTH_SEL(OUT_WIDTH_SEL), .DATA_OUT(DATA_OUT),
	.DATA_OUT_EN_N(DATA_OUT_EN_N), .FULL_FLAG_N(FULL_FLAG_N), .EMPTY_FLAG_N(EMPTY_FLAG_N),
	.ALMOST_EMPTY_N(ALMOST_EMPTY_N), .ALMOST_FULL_N(ALMOST_FULL_N), .HALF_FULL_N(HALF_FULL_N));

`default_nettype wire

// File: tb/dcf_port_host.sv
`timescale 1ns/1ps
`default_nettype none

// port clocks tick only when a transfer is asked for; idle ports stand still
module dcf_port_host (
	input wire logic wr_go,
	input wire logic rd_go,
	output logic wr_clk_en,
	output logic rd_clk_en
);
	assign wr_clk_en = wr_go;
	assign rd_clk_en = rd_go;
endmodule : dcf_port_host

`default_nettype wire

// File: tb/dcf_fifo_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin $display("wrong value %s expected %h seen %h", nm, exp, got); n_mismatch++; end end

module dcf_fifo_ctrl_bench;
	localparam logic [17:0] BW = 18'h2a5c3;
	localparam logic [17:0] BW_HI = {9'h000, BW[17:9]};
	localparam logic [17:0] BW_LO = {9'h000, BW[8:0]};
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic PARTIAL_RST_N = 1'b1;
	logic wr_go = 1'b0;
	logic rd_go = 1'b0;
	logic WRITE_EN_N = 1'b1;
	logic READ_EN_N = 1'b1;
	logic [17:0] DATA_IN = 18'h00000;
	logic TIMING_SEL_SERIAL_IN = 1'b0;
	logic RETRANSMIT_LATENCY_SEL = 1'b0;
	logic RETRANSMIT_REQ_N = 1'b1;
	logic OFFSET_LOAD_N = 1'b0;
	logic OUT_WIDTH_SEL = 1'b0;
	logic FLAG_TIMING_SEL = 1'b0;
	logic DEFAULT_OFFSET_SEL0 = 1'b0;
	logic OUTPUT_EN_N = 1'b0;
	logic tied_lo = 1'b0;
	logic swap = 1'b0;
	logic SERIAL_PROG_EN_N = 1'b1;
	wire logic WR_CLK_EN;
	wire logic RD_CLK_EN;
	logic [17:0] DATA_OUT;
	logic DATA_OUT_EN_N;
	logic FULL_FLAG_N;
	logic EMPTY_FLAG_N;
	logic ALMOST_EMPTY_N;
	logic ALMOST_FULL_N;
	logic HALF_FULL_N;
	integer n_mismatch = 0;
	integer n_checks = 0;

	always #2 CLK = ~CLK;

	dcf_port_host u_host (.wr_go(wr_go), .rd_go(rd_go), .wr_clk_en(WR_CLK_EN),
		.rd_clk_en(RD_CLK_EN));

	dcf_fifo_ctrl DUT (.CLK(CLK), .RST_N(RST_N), .PARTIAL_RST_N(PARTIAL_RST_N),
		.WR_CLK_EN(WR_CLK_EN), .RD_CLK_EN(RD_CLK_EN), .WRITE_EN_N(WRITE_EN_N),
		.READ_EN_N(READ_EN_N), .DATA_IN(DATA_IN), .TIMING_SEL_SERIAL_IN(TIMING_SEL_SERIAL_IN),
		.RETRANSMIT_LATENCY_SEL(RETRANSMIT_LATENCY_SEL), .RETRANSMIT_REQ_N(RETRANSMIT_REQ_N),
		.SERIAL_PROG_EN_N(SERIAL_PROG_EN_N), .OFFSET_LOAD_N(OFFSET_LOAD_N),
		.DEFAULT_OFFSET_SEL0(DEFAULT_OFFSET_SEL0), .DEFAULT_OFFSET_SEL1(tied_lo),
		.IN_WIDTH_SEL(swap), .OUT_WIDTH_SEL(OUT_WIDTH_SEL), .BYTE_ORDER_SEL_N(swap),
		.FLAG_TIMING_SEL(FLAG_TIMING_SEL), .OUTPUT_EN_N(OUTPUT_EN_N), .DATA_OUT(DATA_OUT),
		.DATA_OUT_EN_N(DATA_OUT_EN_N), .FULL_FLAG_N(FULL_FLAG_N), .EMPTY_FLAG_N(EMPTY_FLAG_N),
		.ALMOST_EMPTY_N(ALMOST_EMPTY_N), .ALMOST_FULL_N(ALMOST_FULL_N),
		.HALF_FULL_N(HALF_FULL_N));

	// ********************************
	// port access
	// ********************************
	function automatic logic [17:0] word(input int i);
		return 18'(i) ^ 18'h2a5a5;
	endfunction : word

	// one strobed edge, then an idle edge so strobes never repeat by accident
	task automatic cyc(input logic w, input logic r, input logic wen_n, input logic ren_n,
		input logic retx_n, input logic [17:0] d);
		@(posedge CLK);
		wr_go <= w;
		rd_go <= r;
		WRITE_EN_N <= wen_n;
		READ_EN_N <= ren_n;
		RETRANSMIT_REQ_N <= retx_n;
		DATA_IN <= d;
		@(posedge CLK);
		wr_go <= 1'b0;
		rd_go <= 1'b0;
		RETRANSMIT_REQ_N <= 1'b1;
		@(negedge CLK);
	endtask : cyc

	task automatic strap(input logic ft, input logic lat, input logic out_w, input logic load);
		@(posedge CLK);
		RST_N <= 1'b0;
		TIMING_SEL_SERIAL_IN <= ft;
		RETRANSMIT_LATENCY_SEL <= lat;
		OUT_WIDTH_SEL <= out_w;
		FLAG_TIMING_SEL <= ft;
		DEFAULT_OFFSET_SEL0 <= lat;
		OFFSET_LOAD_N <= load;
		repeat (4) @(posedge CLK);
		RST_N <= 1'b1;
		TIMING_SEL_SERIAL_IN <= !ft;
		RETRANSMIT_LATENCY_SEL <= !lat;
		OUT_WIDTH_SEL <= !out_w;
		OFFSET_LOAD_N <= 1'b1;
		@(negedge CLK);
	endtask : strap

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out

	// ********************************
	// scenarios
	// ********************************
	initial begin
		strap(1'b0, 1'b0, 1'b0, 1'b0);
		`CHK("empty", 1'b0, EMPTY_FLAG_N)
		`CHK("full", 1'b1, FULL_FLAG_N)
		for (int i = 0; i < 3; i++) begin
			cyc(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, word(i));
		end
		cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 18'h00000);
		`CHK("empty", 1'b0, EMPTY_FLAG_N)
		cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 18'h00000);
		`CHK("empty", 1'b1, EMPTY_FLAG_N)
		`CHK("data", 18'h00000, DATA_OUT)
		for (int i = 0; i < 4; i++) begin
			cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 18'h00000);
			`CHK("data", word(i > 2 ? 2 : i), DATA_OUT)
		end
		`CHK("empty", 1'b0, EMPTY_FLAG_N)
		// zero latency tolerates read enable low during the request
		cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 18'h00000);
		`CHK("data", word(0), DATA_OUT)
		cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 18'h00000);
		`CHK("data", word(1), DATA_OUT)
		@(posedge CLK);
		OUTPUT_EN_N <= 1'b1;
		@(negedge CLK);
		`CHK("data_en", 1'b1, DATA_OUT_EN_N)
		@(posedge CLK);
		OUTPUT_EN_N <= 1'b0;
		PARTIAL_RST_N <= 1'b0;
		@(posedge CLK);
		PARTIAL_RST_N <= 1'b1;
		wr_go <= 1'b1;
		WRITE_EN_N <= 1'b0;
		for (int i = 0; i < 8193; i++) begin
			DATA_IN <= word(i);
			@(posedge CLK);
		end
		wr_go <= 1'b0;
		@(negedge CLK);
		`CHK("full", 1'b0, FULL_FLAG_N)
		`CHK("half", 1'b0, HALF_FULL_N)
		`CHK("almost_full", 1'b0, ALMOST_FULL_N)
		`CHK("almost_empty", 1'b1, ALMOST_EMPTY_N)
		// read side learns of the writes only after two read edges
		for (int i = 0; i < 2; i++) begin
			cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 18'h00000);
		end
		`CHK("empty", 1'b1, EMPTY_FLAG_N)
		cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 18'h00000);
		`CHK("data", word(0), DATA_OUT)
		cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 18'h00000);
		`CHK("full", 1'b0, FULL_FLAG_N)
		cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 18'h00000);
		`CHK("full", 1'b1, FULL_FLAG_N)
		strap(1'b1, 1'b1, 1'b1, 1'b1);
		`CHK("ready_out", 1'b1, EMPTY_FLAG_N)
		`CHK("ready_in", 1'b0, FULL_FLAG_N)
		cyc(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, BW);
		for (int i = 0; i < 2; i++) begin
			cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 18'h00000);
			`CHK("ready_out", 1'b1, EMPTY_FLAG_N)
		end
		cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 18'h00000);
		`CHK("ready_out", 1'b0, EMPTY_FLAG_N)
		`CHK("data", BW_HI, DATA_OUT)
		cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 18'h00000);
		`CHK("data", BW_LO, DATA_OUT)
		for (int i = 0; i < 2; i++) begin
			cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 18'h00000);
			`CHK("ready_out", 1'b1, EMPTY_FLAG_N)
			`CHK("data", BW_LO, DATA_OUT)
		end
		// byte-wide writer, lower byte first, serial offset method
		@(posedge CLK);
		swap <= 1'b1;
		strap(1'b0, 1'b1, 1'b0, 1'b1);
		cyc(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, BW_LO);
		cyc(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, BW_HI);
		for (int i = 0; i < 2; i++) begin
			cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 18'h00000);
		end
		cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 18'h00000);
		`CHK("data", BW, DATA_OUT)
		@(posedge CLK);
		OFFSET_LOAD_N <= 1'b0;
		SERIAL_PROG_EN_N <= 1'b0;
		TIMING_SEL_SERIAL_IN <= 1'b1;
		// 14 ones shifted into the default pair of 13'h00ff offsets
		for (int i = 0; i < 14; i++) begin
			cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 18'h00000);
		end
		@(posedge CLK);
		SERIAL_PROG_EN_N <= 1'b1;
		cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 18'h00000);
		`CHK("empty_offset", 18'h001ff, DATA_OUT)
		cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 18'h00000);
		`CHK("full_offset", 18'h01fff, DATA_OUT)
		close_out();
	end

	initial begin
		repeat (60000) @(posedge CLK);
		n_mismatch++;
		close_out();
	end
endmodule : dcf_fifo_ctrl_bench

`undef CHK
`default_nettype wire
